// ==== inc/gis_pkg.sv ====
// constants and types of the graphics instruction sequencer
package gis_pkg;
   localparam logic [7:0] ADDR_PTR_LOW = 8'h00;
   localparam logic [7:0] ADDR_PTR_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_PIX_DLY = 8'h0c;
   localparam logic [7:0] ADDR_ATTR = 8'h10;
   localparam int CTRL_MEM_EN = 0;
   localparam int CTRL_OUT_EN = 1;
   localparam int CTRL_START = 2;
   localparam int CTRL_BUSY = 3;
   localparam int PTRH_CNT_LSB = 7;
   localparam int CLUT_SEL_BIT = 24;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [15:0] PIX_DLY_RST = 16'h0000;
   localparam logic [2:0] VS_LINES = 3'h4;
   localparam logic [23:0] INSTR_BYTES = 24'h000004;
   localparam logic [3:0] OP_LAYER1_ADDR = 4'h8;
   localparam logic [3:0] OP_LAYER1_SIZE = 4'h9;
   localparam logic [3:0] OP_LAYER2_ADDR = 4'ha;
   localparam logic [3:0] OP_LAYER2_SIZE = 4'hb;
   localparam logic [3:0] OP_LAYER2_POS = 4'hc;
   localparam logic [3:0] OP_PALETTE = 4'hd;
   localparam logic [3:0] OP_NOP = 4'he;
   localparam logic [3:0] OP_SCREEN_ATTR = 4'hf;
   localparam logic [3:0] MODE_L1_16 = 4'h0;
   localparam logic [3:0] MODE_L1_8 = 4'h1;
   localparam logic [3:0] MODE_L1_565 = 4'h2;
   localparam logic [3:0] MODE_OFF = 4'h3;
   localparam logic [3:0] MODE_OVERLAP = 4'h6;
   localparam logic [3:0] MODE_EMB_FIRST = 4'h8;
   localparam logic [3:0] MODE_EMB_LAST = 4'hc;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_EXEC = 3'b010,
      ST_WAIT_VS = 3'b011,
      ST_WAIT_FRAME = 3'b100
   } gis_state_t;

   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
      logic italic;
      logic blank;
      logic cor;
   } gis_pix_t;
   localparam gis_pix_t PIX_BLACK = '{red: 4'h0, green: 4'h0, blue: 4'h0, italic: 1'b0,
                                      blank: 1'b1, cor: 1'b0};

   typedef struct packed {
      logic [3:0] opcode;
      logic [27:0] operand;
   } gis_instr_t;

   typedef struct packed {
      logic background_under_layer_transparent;
      logic [3:0] layer_display_mode;
      logic display_double_width;
      logic display_double_height;
      logic [1:0] background_transparency_level;
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
   } gis_attr_t;
endpackage

// ==== logic/gis_top.sv ====
// instruction list sequencer, control registers and output delay stage
`timescale 1ns/1ps
module gis_top (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   output logic O_GA_MEM_REQ,
   output logic [23:0] O_GA_MEM_ADDR,
   input wire logic I_GA_MEM_ACK,
   input wire logic [31:0] I_GA_MEM_RDATA,
   input wire logic I_SRU_MEM_REQ,
   output logic O_SRU_MEM_REQ,
   input wire logic I_SRU_MEM_ACK,
   input wire logic I_VSYNC,
   input wire logic I_HSYNC,
   output logic O_INSTR_VLD,
   output gis_pkg::gis_instr_t O_INSTR,
   output gis_pkg::gis_attr_t O_ATTR,
   output logic O_LAYER1_ON,
   output logic O_LAYER2_ON,
   output logic O_LIST_DONE,
   output logic O_BUSY,
   input wire logic I_PIX_CE,
   input wire gis_pkg::gis_pix_t I_PIX,
   output gis_pkg::gis_pix_t O_PIX
);
   import gis_pkg::*;

   function automatic logic [3:0] dly_pick(input logic [1:0] sel, input logic [3:0] a,
                                           input logic [3:0] b, input logic [3:0] c);
      case (sel)
         2'h1: dly_pick = b;
         2'h2: dly_pick = c;
         default: dly_pick = a;
      endcase
   endfunction

   function automatic logic dly_bit(input logic [1:0] sel, input logic a, b, c);
      dly_bit = (sel == 2'h1) ? b : ((sel == 2'h2) ? c : a);
   endfunction

   function automatic logic mode_known(input logic [3:0] m);
      mode_known = (m <= MODE_OFF) || (m == MODE_OVERLAP) ||
                   (m >= MODE_EMB_FIRST && m <= MODE_EMB_LAST);
   endfunction

   logic ahb_wr_r;
   logic ahb_rd_ok;
   logic [7:0] ahb_addr_r;
   logic [15:0] ptr_low_r;
   logic [15:0] ptr_high_r;
   logic [15:0] ctrl_r;
   logic [15:0] pix_dly_r;
   logic ctrl_mem_en;
   logic ctrl_out_en;
   logic start_d_r;
   logic start_rise;
   gis_state_t state_r;
   logic [23:0] fetch_addr_r;
   logic [8:0] remain_r;
   logic [2:0] line_cnt_r;
   logic in_vs;
   logic issue;
   logic last;
   logic second_palette_load;
   gis_instr_t instr_r;
   gis_pix_t pix_d1_r;
   gis_pix_t pix_d2_r;
   gis_pix_t pix_sel;
   logic [1:0] layers;

   assign ctrl_mem_en = ctrl_r[CTRL_MEM_EN];
   assign ctrl_out_en = ctrl_r[CTRL_OUT_EN];
   assign start_rise = ctrl_r[CTRL_START] && !start_d_r;
   assign in_vs = line_cnt_r < VS_LINES;
   assign last = remain_r == 9'h001;
   assign second_palette_load = instr_r.opcode == OP_PALETTE && instr_r.operand[CLUT_SEL_BIT];

   // bus slave: zero wait states, answer always OKAY
   always_ff @(posedge I_MCLK) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
   end

   assign ahb_rd_ok = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE;

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ahb_wr_r <= 1'b0;
         ahb_addr_r <= 8'h00;
      end else if (I_HREADY) begin
         ahb_wr_r <= I_HSEL && I_HTRANS[1] && I_HWRITE;
         ahb_addr_r <= I_HADDR[7:0];
      end
   end

   // read data is prepared in the address phase so the data phase sees a flop
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_HRDATA <= 32'h00000000;
      end else if (ahb_rd_ok) begin
         case (I_HADDR[7:0])
            ADDR_PTR_LOW: O_HRDATA <= {16'h0000, ptr_low_r};
            ADDR_PTR_HIGH: O_HRDATA <= {16'h0000, ptr_high_r};
            ADDR_CTRL: O_HRDATA <= {16'h0000, ctrl_r[15:4], O_BUSY, ctrl_r[2:0]};
            ADDR_ATTR: O_HRDATA <= {11'h000, O_ATTR};
            default: O_HRDATA <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ptr_low_r <= PTR_RST;
         ptr_high_r <= PTR_RST;
      end else if (ahb_wr_r && ahb_addr_r == ADDR_PTR_LOW) begin
         ptr_low_r <= I_HWDATA[15:0];
      end else if (ahb_wr_r && ahb_addr_r == ADDR_PTR_HIGH) begin
         ptr_high_r <= I_HWDATA[15:0];
      end
   end

   // busy is a live status bit, so only the three low bits are stored
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         ctrl_r <= CTRL_RST;
      end else if (ahb_wr_r && ahb_addr_r == ADDR_CTRL) begin
         ctrl_r <= {13'h0000, I_HWDATA[2:0]};
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         pix_dly_r <= PIX_DLY_RST;
      end else if (ahb_wr_r && ahb_addr_r == ADDR_PIX_DLY) begin
         pix_dly_r <= {4'h0, I_HWDATA[11:0]};
      end
   end

   // lines since field start, saturating just past the sync area
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         line_cnt_r <= VS_LINES;
      end else if (I_VSYNC) begin
         line_cnt_r <= 3'h0;
      end else if (I_HSYNC && in_vs) begin
         line_cnt_r <= line_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge I_MCLK) begin
      start_d_r <= ctrl_r[CTRL_START];
   end

   // an issued instruction goes out one cycle after the cycle that decides it
   always_comb begin
      issue = 1'b0;
      case (state_r)
         ST_EXEC: issue = !(instr_r.opcode[3] && !in_vs) && !second_palette_load;
         ST_WAIT_VS: issue = in_vs;
         ST_WAIT_FRAME: issue = I_VSYNC;
         default: issue = 1'b0;
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_rise && ptr_high_r[15:PTRH_CNT_LSB] != 9'h000) begin
                  state_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (O_GA_MEM_REQ && I_GA_MEM_ACK) begin
                  state_r <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (issue) begin
                  state_r <= last ? ST_IDLE : ST_FETCH;
               end else if (second_palette_load) begin
                  state_r <= ST_WAIT_FRAME;
               end else begin
                  state_r <= ST_WAIT_VS;
               end
            end
            ST_WAIT_VS, ST_WAIT_FRAME: begin
               if (issue) begin
                  state_r <= last ? ST_IDLE : ST_FETCH;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // list pointer is a 23-bit pointer to two-byte units; byte address bit 0 is zero
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         fetch_addr_r <= 24'h000000;
         remain_r <= 9'h000;
      end else if (state_r == ST_IDLE && start_rise) begin
         fetch_addr_r <= {ptr_high_r[6:0], ptr_low_r, 1'b0};
         remain_r <= ptr_high_r[15:PTRH_CNT_LSB];
      end else if (issue) begin
         fetch_addr_r <= fetch_addr_r + INSTR_BYTES;
         remain_r <= remain_r - 9'h001;
      end
   end

   // a request once raised stays until acknowledged, so disabling never cuts it
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_GA_MEM_REQ <= 1'b0;
         O_GA_MEM_ADDR <= 24'h000000;
      end else if (O_GA_MEM_REQ) begin
         O_GA_MEM_REQ <= !I_GA_MEM_ACK;
      end else if (state_r == ST_FETCH && ctrl_mem_en) begin
         O_GA_MEM_REQ <= 1'b1;
         O_GA_MEM_ADDR <= fetch_addr_r;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_SRU_MEM_REQ <= 1'b0;
      end else if (O_SRU_MEM_REQ) begin
         O_SRU_MEM_REQ <= !I_SRU_MEM_ACK;
      end else begin
         O_SRU_MEM_REQ <= I_SRU_MEM_REQ && ctrl_mem_en;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         instr_r <= '0;
      end else if (O_GA_MEM_REQ && I_GA_MEM_ACK) begin
         instr_r <= I_GA_MEM_RDATA;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_INSTR_VLD <= 1'b0;
         O_INSTR <= '0;
         O_LIST_DONE <= 1'b0;
      end else begin
         O_INSTR_VLD <= issue;
         O_LIST_DONE <= (issue && last) ||
                        (state_r == ST_IDLE && start_rise &&
                         ptr_high_r[15:PTRH_CNT_LSB] == 9'h000);
         if (issue) begin
            O_INSTR <= instr_r;
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_BUSY <= 1'b0;
      end else begin
         O_BUSY <= (state_r != ST_IDLE && !(issue && last)) ||
                   (state_r == ST_IDLE && start_rise &&
                    ptr_high_r[15:PTRH_CNT_LSB] != 9'h000);
      end
   end

   // reserved display modes leave the previous mode in force
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_ATTR <= '0;
      end else if (issue && instr_r.opcode == OP_SCREEN_ATTR) begin
         O_ATTR.background_under_layer_transparent <= instr_r.operand[20];
         O_ATTR.display_double_width <= instr_r.operand[15];
         O_ATTR.display_double_height <= instr_r.operand[14];
         O_ATTR.background_transparency_level <= instr_r.operand[13:12];
         O_ATTR.red <= instr_r.operand[11:8];
         O_ATTR.green <= instr_r.operand[7:4];
         O_ATTR.blue <= instr_r.operand[3:0];
         if (mode_known(instr_r.operand[19:16])) begin
            O_ATTR.layer_display_mode <= instr_r.operand[19:16];
         end
      end
   end

   always_comb begin
      case (O_ATTR.layer_display_mode)
         MODE_OFF: layers = 2'b00;
         MODE_L1_16, MODE_L1_8, MODE_L1_565: layers = 2'b01;
         default: layers = 2'b11;
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_LAYER1_ON <= 1'b0;
         O_LAYER2_ON <= 1'b0;
      end else begin
         O_LAYER1_ON <= layers[0];
         O_LAYER2_ON <= layers[1];
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         pix_d1_r <= '0;
         pix_d2_r <= '0;
      end else if (I_PIX_CE) begin
         pix_d1_r <= I_PIX;
         pix_d2_r <= pix_d1_r;
      end
   end

   // code 3 is reserved and behaves as no delay
   always_comb begin
      pix_sel.red = dly_pick(pix_dly_r[1:0], I_PIX.red, pix_d1_r.red, pix_d2_r.red);
      pix_sel.green = dly_pick(pix_dly_r[3:2], I_PIX.green, pix_d1_r.green, pix_d2_r.green);
      pix_sel.blue = dly_pick(pix_dly_r[5:4], I_PIX.blue, pix_d1_r.blue, pix_d2_r.blue);
      pix_sel.italic = dly_bit(pix_dly_r[7:6], I_PIX.italic, pix_d1_r.italic, pix_d2_r.italic);
      pix_sel.blank = dly_bit(pix_dly_r[9:8], I_PIX.blank, pix_d1_r.blank, pix_d2_r.blank);
      pix_sel.cor = dly_bit(pix_dly_r[11:10], I_PIX.cor, pix_d1_r.cor, pix_d2_r.cor);
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         O_PIX <= PIX_BLACK;
      end else if (I_PIX_CE) begin
         if (ctrl_out_en) begin
            O_PIX <= pix_sel;
         end else begin
            O_PIX <= PIX_BLACK;
         end
      end
   end

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);

   sequence fetch_done_s;
      O_GA_MEM_REQ && I_GA_MEM_ACK;
   endsequence

   sequence list_start_s;
      state_r == ST_IDLE && start_rise && ptr_high_r[15:PTRH_CNT_LSB] != 9'h000;
   endsequence

   busy_on_start_a: assert property (list_start_s |=> O_BUSY && state_r == ST_FETCH)
      else $error("busy not raised after start");

   fetch_to_exec_a: assert property (fetch_done_s |=> state_r == ST_EXEC ##0
      instr_r == $past(I_GA_MEM_RDATA))
      else $error("fetched word not taken");

   addr_step_a: assert property (issue && !last |=>
      fetch_addr_r == $past(fetch_addr_r) + INSTR_BYTES)
      else $error("fetch address did not step by four");

   mem_block_a: assert property (!O_GA_MEM_REQ && !ctrl_mem_en |=> !O_GA_MEM_REQ)
      else $error("request raised while memory disabled");

   req_hold_a: assert property (O_GA_MEM_REQ && !I_GA_MEM_ACK |=>
      O_GA_MEM_REQ && $stable(O_GA_MEM_ADDR))
      else $error("pending request dropped");

   out_black_a: assert property (I_PIX_CE && !ctrl_out_en |=>
      O_PIX.red == 4'h0 && O_PIX.blank && !O_PIX.cor)
      else $error("outputs not black while disabled");

   global_gate_a: assert property (O_INSTR_VLD && O_INSTR.opcode[3] &&
      !$past(I_VSYNC) |-> $past(in_vs))
      else $error("global instruction outside sync area");

   palette_wait_a: assert property (O_INSTR_VLD && O_INSTR.opcode == OP_PALETTE &&
      O_INSTR.operand[CLUT_SEL_BIT] |-> $past(I_VSYNC))
      else $error("second palette load not on vsync");

   list_done_a: assert property (O_LIST_DONE |-> !O_BUSY ##1 !O_LIST_DONE)
      else $error("list done while busy or held");

   no_delay_a: assert property (I_PIX_CE && ctrl_out_en && pix_dly_r[1:0] == 2'h0 |=>
      O_PIX.red == $past(I_PIX.red))
      else $error("red delayed with zero delay code");

   dly_reset_a: assert property ($past(I_SYS_RST) |-> pix_dly_r == PIX_DLY_RST)
      else $error("pixel delay not zero after reset");
endmodule

// ==== verification/gis_mem_model.sv ====
// shared instruction memory and refresh-unit arbiter seen from the sequencer
`timescale 1ns/1ps
module gis_mem_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [23:0] i_addr,
   output logic o_ack,
   output logic [31:0] o_rdata,
   input wire logic i_sru_req,
   output logic o_sru_ack,
   input wire logic [3:0] i_delay
);
   // written by the bench as the controller would write the list
   logic [31:0] mem [0:15];
   logic [3:0] wait_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         wait_r <= 4'h0;
         o_rdata <= 32'h0;
      end else if (i_req && !o_ack && wait_r == i_delay) begin
         o_ack <= 1'b1;
         o_rdata <= mem[i_addr[5:2]];
         wait_r <= 4'h0;
      end else begin
         o_ack <= 1'b0;
         // data is only valid with the ack pulse
         o_rdata <= ~o_rdata;
         wait_r <= (i_req && !o_ack) ? wait_r + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge i_clk) begin
      o_sru_ack <= !i_rst && i_sru_req && !o_sru_ack;
   end
endmodule

// ==== verification/test_gis_top.sv ====
// self-checking bench of the instruction sequencer
`timescale 1ns/1ps
module test_gis_top;
   import gis_pkg::*;
   localparam logic [23:0] BASE = 24'h020000;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ce = 1'b0;
   logic vs = 1'b0, hs = 1'b0, sru_req = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ga_rdata, rdv;
   logic hready, hresp, ga_req, ga_ack, sru_o, sru_ack, vld, done, busy, l1, l2;
   logic [23:0] ga_addr;
   logic [3:0] mem_dly = 4'h0;
   logic [15:0] ctrl_v = 16'h0;
   logic [31:0] prog [0:15];
   gis_instr_t instr;
   gis_attr_t attr;
   gis_pix_t pix_i = '0, pix_o;
   logic [31:0] instr_q [$], fetch_q [$];
   int err_count = 0, tests_run = 0, done_n = 0, sru_n = 0, d0 = 0;

   gis_top i_dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .O_GA_MEM_REQ(ga_req), .O_GA_MEM_ADDR(ga_addr), .I_GA_MEM_ACK(ga_ack),
      .I_GA_MEM_RDATA(ga_rdata), .I_SRU_MEM_REQ(sru_req), .O_SRU_MEM_REQ(sru_o),
      .I_SRU_MEM_ACK(sru_ack), .I_VSYNC(vs), .I_HSYNC(hs), .O_INSTR_VLD(vld),
      .O_INSTR(instr), .O_ATTR(attr), .O_LAYER1_ON(l1), .O_LAYER2_ON(l2),
      .O_LIST_DONE(done), .O_BUSY(busy), .I_PIX_CE(ce), .I_PIX(pix_i), .O_PIX(pix_o));
   gis_mem_model i_mem (.i_clk(clk), .i_rst(rst), .i_req(ga_req), .i_addr(ga_addr),
      .o_ack(ga_ack), .o_rdata(ga_rdata), .i_sru_req(sru_o), .o_sru_ack(sru_ack),
      .i_delay(mem_dly));

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      if (!rst) begin
         if (ga_req && ga_ack) fetch_q.push_back({8'h0, ga_addr});
         if (vld) instr_q.push_back(instr);
         if (done) done_n++;
         if (sru_o && sru_ack) sru_n++;
      end
   end

   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task ahb(input logic [7:0] a, input logic w, input logic [15:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask

   task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(a, 1'b0, 16'h0);
      check(name, rdv, exp);
      check("hresp okay", {31'h0, hresp}, 32'h0);
   endtask

   task pulses(input logic v, input int n);
      repeat (n) begin
         @(posedge clk);
         if (v) vs <= 1'b1;
         else hs <= 1'b1;
         @(posedge clk);
         vs <= 1'b0;
         hs <= 1'b0;
      end
   endtask

   task start_list(input int i0, input int n);
      logic [23:0] p;
      p = BASE + 24'(4 * i0);
      for (int i = 0; i < 16; i++) i_mem.mem[i] = prog[i];
      instr_q.delete();
      fetch_q.delete();
      d0 = done_n;
      ahb(ADDR_PTR_LOW, 1'b1, p[16:1]);
      ahb(ADDR_PTR_HIGH, 1'b1, {9'(n), p[23:17]});
      ahb(ADDR_CTRL, 1'b1, ctrl_v);
      ahb(ADDR_CTRL, 1'b1, ctrl_v | 16'h0004);
   endtask

   task finish_list(input int i0, input int n);
      for (int t = 0; t < 300 && done_n == d0; t++) @(posedge clk);
      repeat (2) @(posedge clk);
      check("list done", 32'(done_n - d0), 32'h1);
      check("busy after list", {31'h0, busy}, 32'h0);
      check("instr count", 32'(instr_q.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
         check("fetch addr", fetch_q[i], {8'h0, BASE + 24'(4 * (i0 + i))});
         check("instr", instr_q[i], prog[i0 + i]);
      end
   endtask

   task t_reset;
      rdchk("ctrl reset", ADDR_CTRL, 32'h0);
      rdchk("ptr low reset", ADDR_PTR_LOW, 32'h0);
      rdchk("ptr high reset", ADDR_PTR_HIGH, 32'h0);
      rdchk("pixel delay reset", ADDR_PIX_DLY, 32'h0);
      rdchk("attr reset", ADDR_ATTR, 32'h0);
      check("pix blanked", {pix_o.red, pix_o.green, pix_o.blue, pix_o.blank, pix_o.cor},
         32'h2);
   endtask

   task t_regs;
      ahb(ADDR_PTR_LOW, 1'b1, 16'ha5c3);
      ahb(ADDR_PTR_HIGH, 1'b1, 16'h0281);
      ahb(ADDR_CTRL, 1'b1, 16'h0008);
      ahb(8'h20, 1'b1, 16'hffff);
      rdchk("ptr low", ADDR_PTR_LOW, 32'ha5c3);
      rdchk("ptr high", ADDR_PTR_HIGH, 32'h0281);
      rdchk("busy read only", ADDR_CTRL, 32'h0);
      rdchk("unmapped", 8'h20, 32'h0);
   endtask

   task t_transfer;
      // reserved bits stay zero in every listed word
      for (int i = 0; i < 8; i++) prog[i] = {4'(i), 28'h0a5f00 + 28'(i)};
      mem_dly = 4'h3;
      ctrl_v = 16'h0001;
      // no vsync yet: transfer ops must not wait for the sync area
      start_list(0, 8);
      finish_list(0, 8);
      mem_dly = 4'h0;
   endtask

   task t_restart;
      d0 = done_n;
      ahb(ADDR_CTRL, 1'b1, ctrl_v | 16'h0004);
      repeat (20) @(posedge clk);
      check("no restart", 32'(done_n - d0), 32'h0);
      check("idle busy", {31'h0, busy}, 32'h0);
      start_list(0, 1);
      finish_list(0, 1);
      start_list(0, 0);
      finish_list(0, 0);
   endtask

   task t_global;
      for (int i = 0; i < 6; i++) prog[i] = {4'h8 + 4'(i), 28'h0001200 + 28'(i)};
      prog[5] = {OP_NOP, 28'h0};
      prog[6] = {OP_NOP, 28'h0};
      start_list(0, 6);
      repeat (30) @(posedge clk);
      check("global stalled", 32'(instr_q.size()), 32'h0);
      check("busy stalled", {31'h0, busy}, 32'h1);
      rdchk("busy bit", ADDR_CTRL, 32'h000d);
      pulses(1'b1, 1);
      finish_list(0, 6);
      pulses(1'b0, 3);
      start_list(6, 1);
      finish_list(6, 1);
      pulses(1'b0, 1);
      start_list(6, 1);
      repeat (30) @(posedge clk);
      check("line four outside", 32'(instr_q.size()), 32'h0);
      pulses(1'b1, 1);
      finish_list(6, 1);
   endtask

   task t_palette;
      prog[7] = {OP_PALETTE, 28'h0000155};
      prog[8] = {OP_PALETTE, 28'h1000155};
      start_list(7, 2);
      repeat (30) @(posedge clk);
      check("second palette waits", 32'(instr_q.size()), 32'h1);
      pulses(1'b1, 1);
      finish_list(7, 2);
   endtask

   task t_attr;
      logic [3:0] md [0:7];
      logic [3:0] m;
      md = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'hc, 4'h4};
      for (int i = 0; i < 8; i++) begin
         m = md[i];
         prog[9] = {OP_SCREEN_ATTR, 7'h0, i[0], m, i[1], i[2], 2'(i), 12'h5a0 + 12'(i)};
         start_list(9, 1);
         finish_list(9, 1);
         repeat (2) @(posedge clk);
         if (i < 7) begin
            check("attr", {11'h0, attr}, {11'h0, prog[9][20:0]});
            check("layers", {30'h0, l1, l2}, {30'h0, m != 4'h3, m >= 4'h6});
            rdchk("attr reg", ADDR_ATTR, {11'h0, prog[9][20:0]});
         end else
            check("reserved mode", {28'h0, attr.layer_display_mode}, 32'hc);
      end
   endtask

   task t_memen;
      ctrl_v = 16'h0000;
      ahb(ADDR_CTRL, 1'b1, ctrl_v);
      @(posedge clk);
      sru_req <= 1'b1;
      repeat (10) @(posedge clk);
      check("sru blocked", {31'h0, sru_o}, 32'h0);
      prog[0] = {4'h2, 28'h0000040};
      start_list(0, 1);
      repeat (20) @(posedge clk);
      check("fetch blocked", {31'h0, ga_req}, 32'h0);
      check("busy blocked", {31'h0, busy}, 32'h1);
      ctrl_v = 16'h0001;
      sru_n = 0;
      ahb(ADDR_CTRL, 1'b1, ctrl_v | 16'h0004);
      finish_list(0, 1);
      check("sru passes", 32'(sru_n != 0), 32'h1);
      @(posedge clk);
      sru_req <= 1'b0;
   endtask

   function automatic gis_pix_t mkpix(input int k);
      logic [3:0] v;
      v = k[3:0];
      return '{v, v + 4'h5, v ^ 4'ha, v[1] ^ v[0], v[1], v[2] ^ v[0]};
   endfunction

   task t_pixel;
      gis_pix_t e;
      gis_pix_t hh [0:2];
      int c [0:5];
      logic [15:0] dw;
      int k;
      // layer addresses were loaded by the global list before this
      ctrl_v = 16'h0003;
      ahb(ADDR_CTRL, 1'b1, ctrl_v);
      for (int r = 0; r < 3; r++) begin
         dw = 16'h0;
         for (int f = 0; f < 6; f++) begin
            c[f] = (f + r) % 3;
            dw = dw | (16'(c[f]) << (2 * f));
         end
         ahb(ADDR_PIX_DLY, 1'b1, dw);
         for (int j = 0; j < 8; j++) begin
            k = r * 8 + j;
            @(posedge clk);
            ce <= 1'b1;
            pix_i <= mkpix(k);
            @(posedge clk);
            ce <= 1'b0;
            // idle cycle shows the output holds without an enable
            @(posedge clk);
            hh[0] = mkpix(k);
            hh[1] = mkpix(k - 1);
            hh[2] = mkpix(k - 2);
            e = '{hh[c[0]].red, hh[c[1]].green, hh[c[2]].blue, hh[c[3]].italic,
               hh[c[4]].blank, hh[c[5]].cor};
            if (j >= 2) check("pixel delay", {17'h0, pix_o}, {17'h0, e});
         end
      end
      ahb(ADDR_CTRL, 1'b1, 16'h0001);
      @(posedge clk);
      ce <= 1'b1;
      pix_i <= '{4'hf, 4'hf, 4'hf, 1'b1, 1'b0, 1'b1};
      @(posedge clk);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      check("output off", {pix_o.red, pix_o.green, pix_o.blue, pix_o.blank, pix_o.cor},
         32'h2);
   endtask

   initial begin
      for (int i = 0; i < 16; i++) prog[i] = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_transfer();
      t_restart();
      t_global();
      t_palette();
      t_attr();
      t_memen();
      t_pixel();
      end_of_test();
   end

   // the sequence needs well under ten thousand cycles
   initial begin
      #300000;
      err_count++;
      end_of_test();
   end
endmodule
